// >>> rtl/emoq_params.svh
// Offsets, field positions and reset values of the offload/queue block.
// Assumes a 32-bit Wishbone slave on an 8-bit byte address.
`ifndef EMOQ_PARAMS_SVH
`define EMOQ_PARAMS_SVH
`define EMOQ_OFS_DEV_IP 8'h00
`define EMOQ_OFS_SA0_LOW 8'h04
`define EMOQ_OFS_SA0_HIGH 8'h08
`define EMOQ_OFS_TXQ0_OP 8'h0c
`define EMOQ_OFS_TXQ1_OP 8'h10
`define EMOQ_OFS_TXQ1_SHAPER 8'h14
`define EMOQ_OFS_TL_OP 8'h18
`define EMOQ_OFS_DMA0_TX 8'h1c
`define EMOQ_OFS_DMA1_TX 8'h20
`define EMOQ_OFS_DMA_STS 8'h24
`define EMOQ_OFS_IRQ_MASK 8'h28
`define EMOQ_OFS_CREDIT 8'h2c
`define EMOQ_TXQ_FLUSH_BIT 0
`define EMOQ_TXQ_EN_LSB 2
`define EMOQ_SHP_ALG_BIT 0
`define EMOQ_SHP_CC_BIT 1
`define EMOQ_SHP_IDLE_LSB 8
`define EMOQ_SHP_SEND_LSB 16
`define EMOQ_TL_DROP_STS_BIT 1
`define EMOQ_DMA_RUN_BIT 0
`define EMOQ_DMA_OSF_BIT 4
`define EMOQ_STS_FBE0 0
`define EMOQ_STS_FBE1 1
`define EMOQ_STS_ARP 2
`define EMOQ_STS_IHE 3
`define EMOQ_STS_PCE 4
`define EMOQ_STS_FLUSH 5
`define EMOQ_STS_W 6
`define EMOQ_RST_WORD 32'h0000_0000
`define EMOQ_RST_SLOPE 8'h01
`endif

// >>> rtl/emoq_pkg.sv
// Types of the offload/queue block.
// Assumes the params header holds the numbers.
package emoq_pkg;
  typedef enum logic [1:0] {
    EMOQ_QEN_OFF = 2'b00,
    EMOQ_QEN_GENERIC = 2'b01,
    EMOQ_QEN_AV = 2'b10,
    EMOQ_QEN_RSVD = 2'b11
  } emoq_qen_type;
  typedef logic [47:0] emoq_mac_type;
  typedef logic [31:0] emoq_ip_type;
endpackage : emoq_pkg

// >>> rtl/emoq_arp_filter.sv
// ARP request filter and response generator.
// Assumes parsed request fields on the same clock.
`timescale 1ns/1ps
`default_nettype none
module emoq_arp_filter
  import emoq_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic req_valid_i, // Request present
  output logic req_ready_o, // Request may be taken
  input wire emoq_ip_type req_tpa_i, // Target protocol address
  input wire emoq_ip_type req_spa_i, // Sender protocol address
  input wire emoq_mac_type req_sha_i, // Sender hardware address
  input wire emoq_ip_type dev_ip_i, // Device IP address
  input wire emoq_mac_type station_address_zero_i, // Station address zero
  output logic status_valid_o, // Receive status pulse
  output logic status_arp_ind_o, // ARP indication in status
  output logic resp_valid_o, // Response held
  input wire logic resp_ready_i, // Response taken
  output emoq_mac_type resp_sha_o, // Response sender MAC
  output emoq_ip_type resp_spa_o, // Response sender IP
  output emoq_mac_type resp_tha_o, // Response target MAC
  output emoq_ip_type resp_tpa_o // Response target IP
);
  wire take = req_valid_i & req_ready_o;
  wire ip_hit = (req_tpa_i == dev_ip_i);
  // Straight 48-bit compare: the swapped value is a foreign station
  wire looped = (req_sha_i == station_address_zero_i);
  wire answer = ip_hit & ~looped;
  assign req_ready_o = ~resp_valid_o;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_valid_o <= 1'b0;
      status_arp_ind_o <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_sha_o <= 48'h0;
      resp_spa_o <= 32'h0;
      resp_tha_o <= 48'h0;
      resp_tpa_o <= 32'h0;
    end
    else
    begin
      status_valid_o <= take;
      status_arp_ind_o <= take & answer;
      if (take & answer)
      begin
        resp_valid_o <= 1'b1;
        resp_sha_o <= station_address_zero_i;
        resp_spa_o <= dev_ip_i;
        resp_tha_o <= req_sha_i;
        resp_tpa_o <= req_spa_i;
      end
      else if (resp_ready_i)
      begin
        resp_valid_o <= 1'b0;
      end
    end
  end
endmodule : emoq_arp_filter
`default_nettype wire

// >>> rtl/emoq_cbs_credit.sv
// Shaping credit of one transmit queue.
// Assumes queue and line state on the same clock.
`timescale 1ns/1ps
`default_nettype none
module emoq_cbs_credit #(
  parameter int CREDIT_W = 16
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic shaped_i, // AV queue with shaping on
  input wire logic nonempty_i, // Queue holds data
  input wire logic serving_i, // This queue is on the line
  input wire logic [7:0] idle_slope_i, // Gain per cycle while waiting
  input wire logic [7:0] send_slope_i, // Loss per cycle while sending
  output logic signed [CREDIT_W-1:0] credit_o, // Current credit
  output logic eligible_o // May be served
);
  localparam logic signed [CREDIT_W:0] MAXC = {2'b00, {(CREDIT_W-1){1'b1}}};
  localparam logic signed [CREDIT_W:0] MINC = {2'b11, {(CREDIT_W-1){1'b0}}};
  logic signed [CREDIT_W:0] wide;
  logic signed [CREDIT_W-1:0] next_credit;
  wire signed [CREDIT_W:0] ext = {credit_o[CREDIT_W-1], credit_o};
  always_comb
  begin
    wide = ext;
    if (serving_i)
      wide = ext - $signed({{(CREDIT_W-7){1'b0}}, send_slope_i});
    else
      wide = ext + $signed({{(CREDIT_W-7){1'b0}}, idle_slope_i});
    if (wide > MAXC)
      wide = MAXC;
    else if (wide < MINC)
      wide = MINC;
    next_credit = wide[CREDIT_W-1:0];
    // Empty queues have credit forced to zero so a refill gains no bandwidth
    if (!shaped_i || !nonempty_i)
      next_credit = '0;
  end
  // Unshaped queues are always eligible when holding data
  assign eligible_o = nonempty_i & (~shaped_i | (credit_o > 0));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      credit_o <= '0;
    else
      credit_o <= next_credit;
  end
endmodule : emoq_cbs_credit
`default_nettype wire

// >>> rtl/emoq_top.sv
// Ethernet MAC offload/queue block: ARP, AV shaping, flush,
// checksum flags and transmit DMA bus errors.
// Assumes a Wishbone master and same-clock MAC/DMA logic.
// Behaviour
// - ARP request for device IP compares sender MAC to station address zero.
// - True byte order; identical sender MAC is loop-back, no response.
// - Match without loop-back: send response, flag ARP in status.
// - AV queue: enable field 10; shaping: algorithm 1, credit control 0.
// - Shaped queue eligible only while credit positive; higher credit wins.
// - Waiting non-empty queues gain credit at programmable rate.
// - Transmitting queue loses credit at programmable rate.
// - Empty queues have credit forced to zero.
// - Checksum engine flags IP header and payload checksum errors.
// - Flush bit on queue 0 or 1 makes a dummy status naming the queue.
// - Checksum engine ignores dummy statuses; real status keeps its checksum.
// - Bus error at packet start never aborts MAC-generated packets.
// - Bus error: fatal flag, interrupt, channel run bit cleared.
// - Recovery works for channel 1 with second frame operate set.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`include "emoq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module emoq_top
  import emoq_pkg::*;
#(
  parameter int CREDIT_W = 16
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic irq_o, // Level interrupt
  input wire logic arp_req_valid_i, // Parsed ARP request present
  output logic arp_req_ready_o, // ARP request taken
  input wire logic [31:0] arp_req_tpa_i, // Target protocol address
  input wire logic [31:0] arp_req_spa_i, // Sender protocol address
  input wire logic [47:0] arp_req_sha_i, // Sender hardware address
  output logic rx_status_valid_o, // Receive status pulse
  output logic rx_status_arp_ind_o, // ARP indication in status
  output logic arp_resp_valid_o, // Response pending
  input wire logic arp_resp_ready_i, // Response taken by transmitter
  output logic [47:0] arp_resp_sha_o, // Response sender MAC
  output logic [31:0] arp_resp_spa_o, // Response sender IP
  output logic [47:0] arp_resp_tha_o, // Response target MAC
  output logic [31:0] arp_resp_tpa_o, // Response target IP
  input wire logic [1:0] q_nonempty_i, // Queue holds data
  input wire logic tx_busy_i, // A queue is on the line
  input wire logic tx_busy_queue_i, // Queue on the line
  output logic tx_grant_o, // Start pulse
  output logic tx_grant_queue_o, // Queue to start
  output logic flush_status_valid_o, // Dummy status pulse
  output logic flush_status_queue_o, // Flushed queue
  input wire logic txs_valid_i, // Transmit status from queues
  input wire logic txs_dummy_i, // Status is a flush dummy
  input wire logic [15:0] txs_csum_i, // Checksum field
  input wire logic txs_ihe_i, // IP header error
  input wire logic txs_pce_i, // Payload checksum error
  output logic mac_status_valid_o, // MAC status pulse
  output logic [15:0] mac_status_csum_o, // MAC status checksum
  output logic ip_header_error_flag_o, // Header error of last status
  output logic payload_checksum_error_flag_o, // Payload error of last status
  input wire logic bus_err_i, // DMA slave bus error pulse
  input wire logic bus_err_chan_i, // Channel of the error
  input wire logic sop_i, // Start of packet this cycle
  input wire logic mac_gen_pkt_i, // Packet is MAC generated
  output logic tx_abort_o, // Abort current DMA packet
  output logic [1:0] dma_run_o, // Channel run bits
  output logic [1:0] dma_osf_o, // Second frame operate bits
  output logic [1:0] dma_chan_clear_o // Drop channel fetch state
);
  logic [31:0] device_ip_address_reg;
  logic [31:0] station_addr0_low_reg;
  logic [15:0] station_addr0_high_reg;
  logic [1:0] tx_queue_enable_field [2];
  logic [1:0] tx_queue_flush_bit;
  logic shaper_algorithm_select;
  logic credit_control_bit;
  logic [7:0] idle_slope;
  logic [7:0] send_slope;
  logic drop_tx_status_bit;
  logic [1:0] tx_channel_run_bit;
  logic [1:0] second_frame_operate_bit;
  logic [`EMOQ_STS_W-1:0] dma_channel_status_reg;
  logic [`EMOQ_STS_W-1:0] irq_mask;
  logic signed [CREDIT_W-1:0] credit [2];
  logic [1:0] eligible;
  logic [1:0] shaped;
  logic [1:0] serving;

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wmask = wb_dat_i & bmask;
  wire wr_ip = wr & (wb_adr_i == `EMOQ_OFS_DEV_IP);
  wire wr_sal = wr & (wb_adr_i == `EMOQ_OFS_SA0_LOW);
  wire wr_sah = wr & (wb_adr_i == `EMOQ_OFS_SA0_HIGH);
  wire wr_q0 = wr & (wb_adr_i == `EMOQ_OFS_TXQ0_OP);
  wire wr_q1 = wr & (wb_adr_i == `EMOQ_OFS_TXQ1_OP);
  wire wr_shp = wr & (wb_adr_i == `EMOQ_OFS_TXQ1_SHAPER);
  wire wr_tl = wr & (wb_adr_i == `EMOQ_OFS_TL_OP);
  wire wr_d0 = wr & (wb_adr_i == `EMOQ_OFS_DMA0_TX);
  wire wr_d1 = wr & (wb_adr_i == `EMOQ_OFS_DMA1_TX);
  wire wr_sts = wr & (wb_adr_i == `EMOQ_OFS_DMA_STS);
  wire wr_msk = wr & (wb_adr_i == `EMOQ_OFS_IRQ_MASK);
  wire [1:0] wr_q = {wr_q1, wr_q0};
  wire [1:0] wr_d = {wr_d1, wr_d0};

  // Read mux; unmapped addresses answer zero
  wire [31:0] rd_q0 = {28'h0, tx_queue_enable_field[0], 1'b0, tx_queue_flush_bit[0]};
  wire [31:0] rd_q1 = {28'h0, tx_queue_enable_field[1], 1'b0, tx_queue_flush_bit[1]};
  wire [31:0] rd_shp = {8'h0, send_slope, idle_slope, 6'h0, credit_control_bit,
                        shaper_algorithm_select};
  wire [31:0] rd_d0 = {27'h0, second_frame_operate_bit[0], 3'h0, tx_channel_run_bit[0]};
  wire [31:0] rd_d1 = {27'h0, second_frame_operate_bit[1], 3'h0, tx_channel_run_bit[1]};
  wire [31:0] rd_cr = {credit[1][CREDIT_W-1 -: 16], credit[0][CREDIT_W-1 -: 16]};
  wire [31:0] rd_mux =
    (wb_adr_i == `EMOQ_OFS_DEV_IP) ? device_ip_address_reg :
    (wb_adr_i == `EMOQ_OFS_SA0_LOW) ? station_addr0_low_reg :
    (wb_adr_i == `EMOQ_OFS_SA0_HIGH) ? {16'h0, station_addr0_high_reg} :
    (wb_adr_i == `EMOQ_OFS_TXQ0_OP) ? rd_q0 :
    (wb_adr_i == `EMOQ_OFS_TXQ1_OP) ? rd_q1 :
    (wb_adr_i == `EMOQ_OFS_TXQ1_SHAPER) ? rd_shp :
    (wb_adr_i == `EMOQ_OFS_TL_OP) ? {30'h0, drop_tx_status_bit, 1'b0} :
    (wb_adr_i == `EMOQ_OFS_DMA0_TX) ? rd_d0 :
    (wb_adr_i == `EMOQ_OFS_DMA1_TX) ? rd_d1 :
    (wb_adr_i == `EMOQ_OFS_DMA_STS) ? {26'h0, dma_channel_status_reg} :
    (wb_adr_i == `EMOQ_OFS_IRQ_MASK) ? {26'h0, irq_mask} :
    (wb_adr_i == `EMOQ_OFS_CREDIT) ? rd_cr : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `EMOQ_RST_WORD;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      device_ip_address_reg <= `EMOQ_RST_WORD;
      station_addr0_low_reg <= `EMOQ_RST_WORD;
      station_addr0_high_reg <= 16'h0;
      shaper_algorithm_select <= 1'b0;
      credit_control_bit <= 1'b0;
      idle_slope <= `EMOQ_RST_SLOPE;
      send_slope <= `EMOQ_RST_SLOPE;
      drop_tx_status_bit <= 1'b0;
      irq_mask <= '0;
    end
    else
    begin
      if (wr_ip)
        device_ip_address_reg <= (device_ip_address_reg & ~bmask) | wmask;
      if (wr_sal)
        station_addr0_low_reg <= (station_addr0_low_reg & ~bmask) | wmask;
      if (wr_sah)
        station_addr0_high_reg <= (station_addr0_high_reg & ~bmask[15:0]) | wmask[15:0];
      if (wr_shp & wb_sel_i[0])
      begin
        shaper_algorithm_select <= wb_dat_i[`EMOQ_SHP_ALG_BIT];
        credit_control_bit <= wb_dat_i[`EMOQ_SHP_CC_BIT];
      end
      if (wr_shp & wb_sel_i[1])
        idle_slope <= wb_dat_i[`EMOQ_SHP_IDLE_LSB +: 8];
      if (wr_shp & wb_sel_i[2])
        send_slope <= wb_dat_i[`EMOQ_SHP_SEND_LSB +: 8];
      if (wr_tl & wb_sel_i[0])
        drop_tx_status_bit <= wb_dat_i[`EMOQ_TL_DROP_STS_BIT];
      if (wr_msk & wb_sel_i[0])
        irq_mask <= wb_dat_i[`EMOQ_STS_W-1:0];
    end
  end

  // ARP offload
  emoq_arp_filter u_arp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_valid_i(arp_req_valid_i),
    .req_ready_o(arp_req_ready_o),
    .req_tpa_i(arp_req_tpa_i),
    .req_spa_i(arp_req_spa_i),
    .req_sha_i(arp_req_sha_i),
    .dev_ip_i(device_ip_address_reg),
    .station_address_zero_i({station_addr0_high_reg, station_addr0_low_reg}),
    .status_valid_o(rx_status_valid_o),
    .status_arp_ind_o(rx_status_arp_ind_o),
    .resp_valid_o(arp_resp_valid_o),
    .resp_ready_i(arp_resp_ready_i),
    .resp_sha_o(arp_resp_sha_o),
    .resp_spa_o(arp_resp_spa_o),
    .resp_tha_o(arp_resp_tha_o),
    .resp_tpa_o(arp_resp_tpa_o)
  );
  wire arp_event = rx_status_valid_o & rx_status_arp_ind_o;

  // Per-queue state and shaping
  wire cbs_on = shaper_algorithm_select & ~credit_control_bit;
  genvar q;
  generate
    for (q = 0; q < 2; q++)
    begin : g_queue
      assign shaped[q] = cbs_on & (tx_queue_enable_field[q] == EMOQ_QEN_AV);
      assign serving[q] = tx_busy_i & (tx_busy_queue_i == 1'(q));
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          tx_queue_enable_field[q] <= EMOQ_QEN_OFF;
          tx_channel_run_bit[q] <= 1'b0;
          second_frame_operate_bit[q] <= 1'b0;
        end
        else
        begin
          if (wr_q[q] & wb_sel_i[0])
            tx_queue_enable_field[q] <= wb_dat_i[`EMOQ_TXQ_EN_LSB +: 2];
          if (wr_d[q] & wb_sel_i[0])
          begin
            tx_channel_run_bit[q] <= wb_dat_i[`EMOQ_DMA_RUN_BIT];
            second_frame_operate_bit[q] <= wb_dat_i[`EMOQ_DMA_OSF_BIT];
          end
          // Bus error wins over a same-cycle restart
          if (bus_err_i & (bus_err_chan_i == 1'(q)))
            tx_channel_run_bit[q] <= 1'b0;
        end
      end
      emoq_cbs_credit #(
        .CREDIT_W(CREDIT_W)
      ) u_cbs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .shaped_i(shaped[q]),
        .nonempty_i(q_nonempty_i[q]),
        .serving_i(serving[q]),
        .idle_slope_i(idle_slope),
        .send_slope_i(send_slope),
        .credit_o(credit[q]),
        .eligible_o(eligible[q])
      );
    end
  endgenerate

  // Scheduler: both eligible -> higher credit, ties to queue 0
  wire pick1 = eligible[1] & (~eligible[0] | (credit[1] > credit[0]));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_grant_o <= 1'b0;
      tx_grant_queue_o <= 1'b0;
    end
    else
    begin
      tx_grant_o <= ~tx_busy_i & ~tx_grant_o & (|eligible);
      tx_grant_queue_o <= pick1;
    end
  end

  // Flush: only a queue not on the line is flushed; queue 0 first
  wire [1:0] flush_ok = tx_queue_flush_bit & ~serving;
  wire flush_fire = |flush_ok;
  wire flush_q = ~flush_ok[0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_queue_flush_bit <= 2'b00;
      flush_status_valid_o <= 1'b0;
      flush_status_queue_o <= 1'b0;
    end
    else
    begin
      flush_status_valid_o <= flush_fire;
      flush_status_queue_o <= flush_q;
      if (flush_fire)
        tx_queue_flush_bit[flush_q] <= 1'b0;
      // Software set wins over the self-clear
      if (wr_q0 & wb_sel_i[0] & wb_dat_i[`EMOQ_TXQ_FLUSH_BIT])
        tx_queue_flush_bit[0] <= 1'b1;
      if (wr_q1 & wb_sel_i[0] & wb_dat_i[`EMOQ_TXQ_FLUSH_BIT])
        tx_queue_flush_bit[1] <= 1'b1;
    end
  end

  // Checksum engine: dummy statuses never touch flags or checksum
  wire real_sts = txs_valid_i & ~txs_dummy_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mac_status_valid_o <= 1'b0;
      mac_status_csum_o <= 16'h0;
      ip_header_error_flag_o <= 1'b0;
      payload_checksum_error_flag_o <= 1'b0;
    end
    else
    begin
      mac_status_valid_o <= real_sts & ~drop_tx_status_bit;
      if (real_sts)
      begin
        mac_status_csum_o <= txs_csum_i;
        ip_header_error_flag_o <= txs_ihe_i;
        payload_checksum_error_flag_o <= txs_pce_i;
      end
    end
  end

  // Bus error: abort only DMA-fed packets; generated frames run to the end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_abort_o <= 1'b0;
      dma_chan_clear_o <= 2'b00;
    end
    else
    begin
      tx_abort_o <= bus_err_i & ~mac_gen_pkt_i;
      // Fetch state dropped in every mode: a restart reuses no stale header
      dma_chan_clear_o <= {bus_err_i & bus_err_chan_i, bus_err_i & ~bus_err_chan_i};
    end
  end

  // Sticky status, write one to clear, set wins
  wire [`EMOQ_STS_W-1:0] sts_set;
  assign sts_set[`EMOQ_STS_FBE0] = bus_err_i & ~bus_err_chan_i;
  assign sts_set[`EMOQ_STS_FBE1] = bus_err_i & bus_err_chan_i;
  assign sts_set[`EMOQ_STS_ARP] = arp_event;
  assign sts_set[`EMOQ_STS_IHE] = real_sts & txs_ihe_i;
  assign sts_set[`EMOQ_STS_PCE] = real_sts & txs_pce_i;
  assign sts_set[`EMOQ_STS_FLUSH] = flush_fire;
  wire [`EMOQ_STS_W-1:0] sts_clr = (wr_sts & wb_sel_i[0]) ? wb_dat_i[`EMOQ_STS_W-1:0] : '0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dma_channel_status_reg <= '0;
    else
      dma_channel_status_reg <= (dma_channel_status_reg & ~sts_clr) | sts_set;
  end

  assign irq_o = |(dma_channel_status_reg & irq_mask);
  assign dma_run_o = tx_channel_run_bit;
  assign dma_osf_o = second_frame_operate_bit;
endmodule : emoq_top
`default_nettype wire

// >>> sim/emoq_top_assertions.sv
// Port checks of the offload/queue block.
// Assumes one clock, synchronous high reset.
`timescale 1ns/1ps
`default_nettype none
module emoq_chk (
  input wire logic clk_i, // clk
  input wire logic rst_i, // rst
  input wire logic wb_cyc_i, // in
  input wire logic wb_stb_i, // in
  input wire logic [31:0] wb_dat_o, // in
  input wire logic wb_ack_o, // in
  input wire logic arp_req_valid_i, // in
  input wire logic arp_req_ready_o, // in
  input wire logic arp_resp_ready_i, // in
  input wire logic arp_resp_valid_o, // in
  input wire logic rx_status_valid_o, // in
  input wire logic tx_busy_i, // in
  input wire logic tx_grant_o, // in
  input wire logic txs_valid_i, // in
  input wire logic txs_dummy_i, // in
  input wire logic mac_status_valid_o, // in
  input wire logic ip_header_error_flag_o, // in
  input wire logic bus_err_i, // in
  input wire logic bus_err_chan_i, // in
  input wire logic mac_gen_pkt_i, // in
  input wire logic tx_abort_o, // in
  input wire logic [1:0] dma_run_o // in
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one pulse");
  chk_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_arp_status: assert property (arp_req_valid_i && arp_req_ready_o |=> rx_status_valid_o)
    else $error("no status for request");
  chk_resp_hold: assert property (arp_resp_valid_o && !arp_resp_ready_i |=> arp_resp_valid_o && !arp_req_ready_o)
    else $error("response dropped");
  chk_busy_nogrant: assert property (tx_busy_i |=> !tx_grant_o)
    else $error("grant while busy");
  chk_dummy_skip: assert property (txs_valid_i && txs_dummy_i |=> !mac_status_valid_o && $stable(ip_header_error_flag_o))
    else $error("dummy status used");
  chk_gen_noabort: assert property (bus_err_i && mac_gen_pkt_i |=> !tx_abort_o)
    else $error("generated packet aborted");
  chk_run_stop: assert property (bus_err_i |=> (dma_run_o & (2'b01 << $past(bus_err_chan_i))) == 2'b00)
    else $error("run bit kept");
endmodule : emoq_chk
bind emoq_top emoq_chk u_chk (.*);
`default_nettype wire

// >>> sim/emoq_line_model.sv
// Line transmitter: raises ready DELAY+1 cycles after a response is offered.
// Assumes a valid/ready handshake on one clock.
`timescale 1ns/1ps
`default_nettype none
module emoq_line_model #(
  parameter int DELAY = 2
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic resp_valid_i, // Response offered
  output logic resp_ready_o // Response taken
);
  int waited;
  // A busy line keeps the response waiting; ready lasts one cycle
  always_ff @(posedge clk_i)
  begin
    waited <= (rst_i || !resp_valid_i || resp_ready_o) ? 0 : waited + 1;
    resp_ready_o <= !rst_i && resp_valid_i && !resp_ready_o && waited >= DELAY;
  end
endmodule : emoq_line_model
`default_nettype wire

// >>> sim/emoq_top_bench.sv
// Self-checking bench of the offload/queue block.
// Assumes the checker and line model compile alongside.
`include "emoq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module emoq_top_bench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, arp_req_valid_i;
  logic arp_req_ready_o, rx_status_valid_o, rx_status_arp_ind_o, arp_resp_valid_o;
  logic arp_resp_ready_i, tx_busy_i, tx_busy_queue_i, tx_grant_o, tx_grant_queue_o;
  logic flush_status_valid_o, flush_status_queue_o, txs_valid_i, txs_dummy_i, txs_ihe_i;
  logic txs_pce_i, mac_status_valid_o, ip_header_error_flag_o, payload_checksum_error_flag_o;
  logic bus_err_i, bus_err_chan_i, sop_i, mac_gen_pkt_i, tx_abort_o, fq;
  logic [1:0] q_nonempty_i, dma_run_o, dma_osf_o, dma_chan_clear_o;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i;
  logic [15:0] txs_csum_i, mac_status_csum_o;
  logic [31:0] wb_dat_i, wb_dat_o, arp_req_tpa_i, arp_req_spa_i, arp_resp_spa_o, arp_resp_tpa_o, rd;
  logic [47:0] arp_req_sha_i, arp_resp_sha_o, arp_resp_tha_o;
  int num_errors = 0, samples_checked = 0, flushes = 0, grants = 0, msts = 0;
  emoq_top u_dut (.*);
  emoq_line_model #(.DELAY(2)) u_line (.clk_i(clk_i), .rst_i(rst_i),
    .resp_valid_i(arp_resp_valid_o), .resp_ready_o(arp_resp_ready_i));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Pulses counted at the edge, before they change
  always @(posedge clk_i)
  begin
    if (flush_status_valid_o === 1'b1) {flushes, fq} = {flushes + 1, flush_status_queue_o};
    if (tx_grant_o === 1'b1) grants++;
    if (mac_status_valid_o === 1'b1) msts++;
  end
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic cmp(input string what, input logic [47:0] e, input logic [47:0] s);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
    begin
      num_errors++;
      end_of_test();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(what, e, rd);
  endtask : rdc
  task automatic arp(input logic [47:0] sha, input logic [31:0] tpa);
    {arp_req_valid_i, arp_req_sha_i, arp_req_tpa_i, arp_req_spa_i} <= {1'b1, sha, tpa, 32'h0a000002};
    @(posedge clk_i);
    arp_req_valid_i <= 1'b0;
    @(negedge clk_i);
    cmp("status", 1, rx_status_valid_o);
  endtask : arp
  task automatic berr(input logic ch, input logic gen);
    {bus_err_i, bus_err_chan_i, sop_i, mac_gen_pkt_i} <= {1'b1, ch, 1'b1, gen};
    @(posedge clk_i);
    {bus_err_i, sop_i} <= 2'b00;
    @(negedge clk_i);
    cmp("abort", !gen, tx_abort_o);
  endtask : berr
  initial
  begin
    rst_i = 1'b1;
    wb_sel_i = 4'hf;
    {wb_cyc_i, wb_stb_i, arp_req_valid_i, q_nonempty_i, tx_busy_i, txs_valid_i, bus_err_i} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("status", `EMOQ_OFS_DMA_STS, 32'h0);
    rdc("shaper", `EMOQ_OFS_TXQ1_SHAPER, 32'h00010100);
    wb(1'b1, 8'h40, 32'hffffffff);
    rdc("unmapped", 8'h40, 32'h0);
    wb(1'b1, `EMOQ_OFS_IRQ_MASK, 32'h3);
    wb(1'b1, `EMOQ_OFS_DEV_IP, 32'hc0a80107);
    wb(1'b1, `EMOQ_OFS_SA0_LOW, 32'h44332211);
    wb(1'b1, `EMOQ_OFS_SA0_HIGH, 32'h6655);
    $display("test registers done");
    arp(48'h665544332211, 32'hc0a80107);
    cmp("loopback resp", 0, arp_resp_valid_o);
    @(posedge clk_i);
    arp(48'h112233445566, 32'hc0a80107);
    cmp("indication", 1, rx_status_arp_ind_o);
    cmp("resp sha", 48'h665544332211, arp_resp_sha_o);
    cmp("resp spa", 32'hc0a80107, arp_resp_spa_o);
    cmp("resp tha", 48'h112233445566, arp_resp_tha_o);
    cmp("resp tpa", 32'h0a000002, arp_resp_tpa_o);
    for (int n = 0; n < 10 && arp_resp_valid_o !== 1'b0; n++) @(negedge clk_i);
    cmp("resp taken", 0, arp_resp_valid_o);
    @(posedge clk_i);
    arp(48'h112233445566, 32'hc0a80108);
    cmp("ip miss ind", 0, rx_status_arp_ind_o);
    @(posedge clk_i);
    $display("test arp done");
    wb(1'b1, `EMOQ_OFS_TXQ1_OP, 32'h1);
    for (int n = 0; n < 10 && flushes == 0; n++) @(posedge clk_i);
    cmp("flush count", 1, flushes);
    cmp("flush queue", 1, fq);
    rdc("flush bit", `EMOQ_OFS_TXQ1_OP, 32'h0);
    {txs_valid_i, txs_csum_i, txs_ihe_i, txs_pce_i} <= {1'b1, 16'hbeef, 2'b11};
    @(posedge clk_i);
    {txs_dummy_i, txs_csum_i, txs_ihe_i, txs_pce_i} <= {1'b1, 18'h0};
    @(posedge clk_i);
    txs_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp("mac statuses", 1, msts);
    cmp("csum", 16'hbeef, mac_status_csum_o);
    cmp("flags", 2'b11, {ip_header_error_flag_o, payload_checksum_error_flag_o});
    cmp("masked irq", 0, irq_o);
    $display("test flush done");
    wb(1'b1, `EMOQ_OFS_DMA0_TX, 32'h1);
    wb(1'b1, `EMOQ_OFS_DMA1_TX, 32'h11);
    berr(1'b0, 1'b1);
    cmp("run", 2'b10, dma_run_o);
    cmp("irq", 1, irq_o);
    @(posedge clk_i);
    berr(1'b1, 1'b0);
    cmp("run osf", 4'b0010, {dma_run_o, dma_osf_o});
    @(posedge clk_i);
    rdc("status", `EMOQ_OFS_DMA_STS, 32'h3f);
    wb(1'b1, `EMOQ_OFS_DMA_STS, 32'h3);
    rdc("cleared", `EMOQ_OFS_DMA_STS, 32'h3c);
    wb(1'b1, `EMOQ_OFS_DMA1_TX, 32'h11);
    cmp("restart", 2'b10, dma_run_o);
    cmp("irq off", 0, irq_o);
    $display("test bus error done");
    wb(1'b1, `EMOQ_OFS_TXQ1_SHAPER, 32'h00020301);
    wb(1'b1, `EMOQ_OFS_TXQ0_OP, 32'h8);
    {q_nonempty_i, tx_busy_i, tx_busy_queue_i} <= 4'b0111;
    @(posedge clk_i);
    rdc("credit", `EMOQ_OFS_CREDIT, 32'h3);
    cmp("q0 gains", 1, rd[15:0] != 0 && !rd[15]);
    tx_busy_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmp("granted", 1, grants != 0);
    q_nonempty_i <= 2'b00;
    @(posedge clk_i);
    rdc("credit", `EMOQ_OFS_CREDIT, 32'h0);
    $display("test shaping done");
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("reset sts", `EMOQ_OFS_DMA_STS, 32'h0);
    cmp("reset run", 0, dma_run_o);
    $display("test reset done");
    end_of_test();
  end
endmodule : emoq_top_bench
`default_nettype wire
